// [src/ssc_pkg.sv]
// Behaviour
// - PLL mode multiplies crystal clock by four
// - Multiplier enabled only in PLL crystal mode
// - External clock modes skip oscillator start-up delay
// - External clock divout mode drives clock/4 out
// - External clock gpio mode frees out pin
// - RC divout mode drives clock/4 on out
// - RC gpio mode frees out pin as bit6
// - Fast internal oscillator 8 MHz with postscaler
// - Fast oscillator on for 125 kHz-8 MHz selections
// - Slow oscillator on for internal or features
// - Select field picks fast, slow or postscaler
// - One-pin mode: clock/4 out, in pin bit7
// - Two-pin mode: both pins general I/O
// - Trim field is signed offset around centre
// - Top two trim bits read zero
// - Slow settles in 8 cycles, fast 1 ms
// - No completion flag for frequency shift
// - Every trim step changes frequency equally
// - High-speed mode accepts external clock input
// - Select 111 fast, 110-001 postscaler, 000 slow
// - Ten modes from 4-bit configuration field
package ssc_pkg;
    localparam longint unsigned SYS_HZ          = 250_000_000;
    localparam int unsigned     SYS_PERIOD_NS   = 4;
    localparam longint unsigned FAST_HZ         = 8_000_000;
    localparam longint unsigned SLOW_HZ         = 31_250;
    localparam int unsigned     ACC_W           = 24;
    // Phase steps of the oscillator models, derived from the nominal rates
    localparam logic signed [24:0] FAST_STEP =
        25'((FAST_HZ * (64'd1 << ACC_W)) / SYS_HZ);
    localparam logic signed [24:0] SLOW_STEP =
        25'((SLOW_HZ * (64'd1 << ACC_W)) / SYS_HZ);
    localparam logic signed [24:0] FAST_TRIM_UNIT  = 25'sh0001062;
    localparam logic signed [24:0] SLOW_TRIM_UNIT  = 25'sh0000010;
    localparam int unsigned     FAST_SETTLE_NS  = 1_000_000;
    localparam int unsigned     FAST_SETTLE_CYC = FAST_SETTLE_NS / SYS_PERIOD_NS;
    localparam int unsigned     OST_EDGES       = 1024;
    localparam int unsigned     PLL_MULT        = 4;
    localparam int unsigned     PLL_MULT_SHIFT  = 2;

    localparam logic [7:0] ADDR_TRIM    = 8'h00;
    localparam logic [7:0] ADDR_CTRL    = 8'h01;
    localparam logic [7:0] ADDR_STATUS  = 8'h02;
    localparam logic [5:0] TRIM_RESET   = 6'h00;
    localparam logic [2:0] SEL_RESET    = 3'h0;
    localparam logic [2:0] SEL_FAST     = 3'h7;
    localparam logic [2:0] SEL_SLOW     = 3'h0;
    localparam int unsigned CTRL_SEL_LSB = 4;

    localparam logic [3:0] CFG_LP       = 4'h0;
    localparam logic [3:0] CFG_XT       = 4'h1;
    localparam logic [3:0] CFG_HI_SPD   = 4'h2;
    localparam logic [3:0] CFG_RC_DIV   = 4'h3;
    localparam logic [3:0] CFG_EXT_DIV  = 4'h4;
    localparam logic [3:0] CFG_EXT_IO   = 4'h5;
    localparam logic [3:0] CFG_PLL      = 4'h6;
    localparam logic [3:0] CFG_RC_IO    = 4'h7;
    localparam logic [3:0] CFG_INT_ONE  = 4'h8;
    localparam logic [3:0] CFG_INT_TWO  = 4'h9;

    typedef enum logic [3:0] {
        low_power_crystal_mode,
        standard_crystal_mode,
        high_speed_crystal_mode,
        pll_x4_crystal_mode,
        resistor_cap_divout_mode,
        resistor_cap_gpio_mode,
        ext_clock_divout_mode,
        ext_clock_gpio_mode,
        internal_osc_one_pin_mode,
        internal_osc_two_pin_mode
    } ssc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ssc_bus_req_t;

    typedef struct packed {
        logic pwrt;
        logic fscm;
        logic wdt;
        logic two_speed;
    } ssc_feat_t;

    typedef struct packed {
        logic bit6_out;
        logic bit6_oe;
        logic bit7_out;
        logic bit7_oe;
    } ssc_gp_drv_t;
endpackage

// [src/ssc_clock_select.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_clock_select #(
    parameter int unsigned FAST_SETTLE_CYC = ssc_pkg::FAST_SETTLE_CYC,
    parameter int unsigned OST_EDGES       = ssc_pkg::OST_EDGES,
    parameter int unsigned PER_W           = 16
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire ssc_pkg::ssc_bus_req_t bus_req,
    output logic [7:0]                bus_rdata,
    input  wire logic [3:0]           osc_mode_config,
    input  wire ssc_pkg::ssc_feat_t   feat_en,
    input  wire ssc_pkg::ssc_gp_drv_t gp_first_drv,
    output logic                      gp_first_bit6,
    output logic                      gp_first_bit7,
    input  wire logic                 osc_in_pin_sense,
    output logic                      osc_in_pin_drive,
    output logic                      osc_in_pin_oe,
    input  wire logic                 osc_out_pin_sense,
    output logic                      osc_out_pin_drive,
    output logic                      osc_out_pin_oe,
    output logic                      fosc_tick,
    output logic                      sys_clk_ready,
    output logic                      pll_en,
    output logic                      fast_osc_en,
    output logic                      slow_osc_en,
    output var ssc_pkg::ssc_mode_t    osc_mode
);

    function automatic ssc_pkg::ssc_mode_t decode_mode(input logic [3:0] cfg);
        ssc_pkg::ssc_mode_t m;
        unique case (cfg)
            ssc_pkg::CFG_LP:      m = ssc_pkg::low_power_crystal_mode;
            ssc_pkg::CFG_XT:      m = ssc_pkg::standard_crystal_mode;
            ssc_pkg::CFG_HI_SPD:  m = ssc_pkg::high_speed_crystal_mode;
            ssc_pkg::CFG_PLL:     m = ssc_pkg::pll_x4_crystal_mode;
            ssc_pkg::CFG_RC_DIV:  m = ssc_pkg::resistor_cap_divout_mode;
            ssc_pkg::CFG_RC_IO:   m = ssc_pkg::resistor_cap_gpio_mode;
            ssc_pkg::CFG_EXT_DIV: m = ssc_pkg::ext_clock_divout_mode;
            ssc_pkg::CFG_EXT_IO:  m = ssc_pkg::ext_clock_gpio_mode;
            ssc_pkg::CFG_INT_ONE: m = ssc_pkg::internal_osc_one_pin_mode;
            ssc_pkg::CFG_INT_TWO: m = ssc_pkg::internal_osc_two_pin_mode;
            // Unused codes fall back to the high-speed crystal mode, the safest analog setting
            default:              m = ssc_pkg::high_speed_crystal_mode;
        endcase
        return m;
    endfunction

    logic       cfg_loaded;
    logic [5:0] freq_trim;
    logic [5:0] trim_fast;
    logic [5:0] trim_slow;
    logic [2:0] internal_freq_select;
    logic [31:0] settle_cnt;
    logic       settle_busy;
    logic       trim_wr;
    logic       is_crystal;
    logic       is_internal;
    logic       is_ext;
    logic       divout;
    logic       gp6_io;
    logic       gp7_io;
    logic [ssc_pkg::ACC_W-1:0] fast_acc;
    logic [ssc_pkg::ACC_W-1:0] slow_acc;
    logic signed [24:0] fast_step;
    logic signed [24:0] slow_step;
    logic [ssc_pkg::ACC_W:0] next_fast_acc;
    logic [ssc_pkg::ACC_W:0] next_slow_acc;
    logic       fast_tick;
    logic       slow_tick;
    logic [5:0] psc_cnt;
    logic [5:0] psc_mask;
    logic       int_tick;
    logic       in_s1;
    logic       in_s2;
    logic       in_s3;
    logic       out_s1;
    logic       out_s2;
    logic       ext_tick;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] quarter;
    logic [PER_W-1:0] gen_cnt;
    logic       pll_tick;
    logic [31:0] ost_cnt;
    logic       src_tick;
    logic [1:0] div4_cnt;
    logic       fosc_div4;

    // The configuration word is static storage, captured once after reset release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_loaded <= 1'b0;
            osc_mode   <= ssc_pkg::high_speed_crystal_mode;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            osc_mode   <= decode_mode(osc_mode_config);
        end
    end

    always_comb begin
        is_crystal  = 1'b0;
        is_internal = 1'b0;
        is_ext      = 1'b0;
        divout      = 1'b0;
        gp6_io      = 1'b0;
        gp7_io      = 1'b0;
        unique case (osc_mode)
            ssc_pkg::low_power_crystal_mode,
            ssc_pkg::standard_crystal_mode,
            ssc_pkg::high_speed_crystal_mode,
            ssc_pkg::pll_x4_crystal_mode:   is_crystal = 1'b1;
            ssc_pkg::resistor_cap_divout_mode: divout = 1'b1;
            ssc_pkg::resistor_cap_gpio_mode:   gp6_io = 1'b1;
            ssc_pkg::ext_clock_divout_mode: begin
                is_ext = 1'b1;
                divout = 1'b1;
            end
            ssc_pkg::ext_clock_gpio_mode: begin
                is_ext = 1'b1;
                gp6_io = 1'b1;
            end
            ssc_pkg::internal_osc_one_pin_mode: begin
                is_internal = 1'b1;
                divout      = 1'b1;
                gp7_io      = 1'b1;
            end
            ssc_pkg::internal_osc_two_pin_mode: begin
                is_internal = 1'b1;
                gp6_io      = 1'b1;
                gp7_io      = 1'b1;
            end
        endcase
    end

    assign pll_en      = cfg_loaded && (osc_mode == ssc_pkg::pll_x4_crystal_mode);
    assign fast_osc_en = is_internal && (internal_freq_select != ssc_pkg::SEL_SLOW);
    assign slow_osc_en = is_internal || feat_en.pwrt || feat_en.fscm
                         || feat_en.wdt || feat_en.two_speed;

    // Register port
    assign trim_wr = bus_req.wr && (bus_req.addr == ssc_pkg::ADDR_TRIM);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_trim <= ssc_pkg::TRIM_RESET;
        end else if (trim_wr) begin
            freq_trim <= bus_req.wdata[5:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            internal_freq_select <= ssc_pkg::SEL_RESET;
        end else if (bus_req.wr && (bus_req.addr == ssc_pkg::ADDR_CTRL)) begin
            internal_freq_select <= bus_req.wdata[ssc_pkg::CTRL_SEL_LSB +: 3];
        end
    end

    // Reads give data in the next cycle only; the settle state is kept private
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ssc_pkg::ADDR_TRIM:   bus_rdata <= {2'b00, freq_trim};
                ssc_pkg::ADDR_CTRL:   bus_rdata <= {1'b0, internal_freq_select, 4'h0};
                ssc_pkg::ADDR_STATUS: bus_rdata <= {sys_clk_ready, slow_osc_en, fast_osc_en,
                                                   pll_en, osc_mode};
                default:              bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Fast oscillator picks up a new trim once its settle time has passed
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt  <= 32'h0;
            settle_busy <= 1'b0;
            trim_fast   <= ssc_pkg::TRIM_RESET;
        end else if (trim_wr) begin
            settle_cnt  <= FAST_SETTLE_CYC - 32'h1;
            settle_busy <= 1'b1;
        end else if (settle_busy) begin
            if (settle_cnt == 32'h0) begin
                settle_busy <= 1'b0;
                trim_fast   <= freq_trim;
            end else begin
                settle_cnt <= settle_cnt - 32'h1;
            end
        end
    end

    // Slow oscillator takes the trim on its next edge, well inside eight periods
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            trim_slow <= ssc_pkg::TRIM_RESET;
        end else if (slow_tick) begin
            trim_slow <= freq_trim;
        end
    end

    // Signed trim times a fixed unit keeps every step the same size
    assign fast_step = ssc_pkg::FAST_STEP
                       + ssc_pkg::FAST_TRIM_UNIT * 25'(signed'(trim_fast));
    assign slow_step = ssc_pkg::SLOW_STEP
                       + ssc_pkg::SLOW_TRIM_UNIT * 25'(signed'(trim_slow));
    assign next_fast_acc = {1'b0, fast_acc} + {1'b0, fast_step[ssc_pkg::ACC_W-1:0]};
    assign next_slow_acc = {1'b0, slow_acc} + {1'b0, slow_step[ssc_pkg::ACC_W-1:0]};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_acc  <= '0;
            fast_tick <= 1'b0;
        end else if (fast_osc_en) begin
            fast_acc  <= next_fast_acc[ssc_pkg::ACC_W-1:0];
            fast_tick <= next_fast_acc[ssc_pkg::ACC_W];
        end else begin
            fast_tick <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_acc  <= '0;
            slow_tick <= 1'b0;
        end else if (slow_osc_en) begin
            slow_acc  <= next_slow_acc[ssc_pkg::ACC_W-1:0];
            slow_tick <= next_slow_acc[ssc_pkg::ACC_W];
        end else begin
            slow_tick <= 1'b0;
        end
    end

    // Postscaler: select 6 halves the fast clock, select 1 divides it by 64
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            psc_cnt <= 6'h00;
        end else if (fast_tick) begin
            psc_cnt <= psc_cnt + 6'h01;
        end
    end

    assign psc_mask = 6'(6'h3f >> (internal_freq_select - 3'h1));

    always_comb begin
        unique case (internal_freq_select)
            ssc_pkg::SEL_FAST: int_tick = fast_tick;
            ssc_pkg::SEL_SLOW: int_tick = slow_tick;
            default:           int_tick = fast_tick && ((psc_cnt & psc_mask) == psc_mask);
        endcase
    end

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_s1  <= 1'b0;
            in_s2  <= 1'b0;
            in_s3  <= 1'b0;
            out_s1 <= 1'b0;
            out_s2 <= 1'b0;
        end else begin
            in_s1  <= osc_in_pin_sense;
            in_s2  <= in_s1;
            in_s3  <= in_s2;
            out_s1 <= osc_out_pin_sense;
            out_s2 <= out_s1;
        end
    end

    // A crystal or an injected clock looks the same once squared up
    assign ext_tick = in_s2 && !in_s3;

    // Multiplier: measure the input period, then emit a tick every quarter of it
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_cnt <= '0;
            quarter <= '0;
        end else if (!pll_en) begin
            per_cnt <= '0;
            quarter <= '0;
        end else if (ext_tick) begin
            per_cnt <= '0;
            quarter <= PER_W'((per_cnt + PER_W'(1)) >> ssc_pkg::PLL_MULT_SHIFT);
        end else if (per_cnt != '1) begin
            per_cnt <= per_cnt + PER_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gen_cnt  <= '0;
            pll_tick <= 1'b0;
        end else if (!pll_en || quarter == '0) begin
            gen_cnt  <= '0;
            pll_tick <= 1'b0;
        end else if (ext_tick || gen_cnt == '0) begin
            gen_cnt  <= quarter - PER_W'(1);
            pll_tick <= 1'b1;
        end else begin
            gen_cnt  <= gen_cnt - PER_W'(1);
            pll_tick <= 1'b0;
        end
    end

    // Crystal modes wait for the start-up count; all other modes are ready at once
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ost_cnt       <= 32'h0;
            sys_clk_ready <= 1'b0;
        end else if (!cfg_loaded) begin
            sys_clk_ready <= 1'b0;
        end else if (!is_crystal) begin
            sys_clk_ready <= 1'b1;
        end else if (!sys_clk_ready && ext_tick) begin
            ost_cnt       <= ost_cnt + 32'h1;
            sys_clk_ready <= (ost_cnt + 32'h1) >= OST_EDGES;
        end
    end

    always_comb begin
        if (osc_mode == ssc_pkg::pll_x4_crystal_mode) begin
            src_tick = pll_tick;
        end else if (is_internal) begin
            src_tick = int_tick;
        end else begin
            src_tick = ext_tick;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fosc_tick <= 1'b0;
        end else begin
            fosc_tick <= sys_clk_ready && src_tick;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div4_cnt <= 2'h0;
        end else if (fosc_tick) begin
            div4_cnt <= div4_cnt + 2'h1;
        end
    end

    assign fosc_div4 = div4_cnt[1];

    // Crystal modes leave the pins to the analog amplifier, so no digital drive
    assign osc_out_pin_drive = divout ? fosc_div4
                               : (gp6_io && gp_first_drv.bit6_out);
    assign osc_out_pin_oe    = divout || (gp6_io && gp_first_drv.bit6_oe);
    assign osc_in_pin_drive  = gp7_io && gp_first_drv.bit7_out;
    assign osc_in_pin_oe     = gp7_io && gp_first_drv.bit7_oe;
    assign gp_first_bit6  = gp6_io && out_s2;
    assign gp_first_bit7  = gp7_io && in_s2;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_pll_mode_only: assert property (cfg_loaded |->
        (pll_en == (osc_mode == ssc_pkg::pll_x4_crystal_mode)))
        else $error("multiplier enable does not follow the mode");

    a_ext_no_startup: assert property ((cfg_loaded && is_ext) |=> sys_clk_ready)
        else $error("external clock mode waited for start-up");

    a_div4_rise: assert property ((divout && fosc_tick && div4_cnt == 2'h1) |=>
        (osc_out_pin_drive && osc_out_pin_oe && $rose(fosc_div4)))
        else $error("clock divided by four missing on out pin");

    a_gpio6_route: assert property (gp6_io |->
        (osc_out_pin_drive == gp_first_drv.bit6_out && osc_out_pin_oe == gp_first_drv.bit6_oe))
        else $error("out pin not routed as general I/O");

    a_trim_upper_zero: assert property ((bus_req.rd && bus_req.addr == ssc_pkg::ADDR_TRIM) |=>
        (bus_rdata[7:6] == 2'b00 && bus_rdata[5:0] == $past(freq_trim)))
        else $error("trim read back wrong");

    a_trim_reset_centre: assert property (!cfg_loaded |-> freq_trim == ssc_pkg::TRIM_RESET)
        else $error("trim not at centre after reset");

    a_slow_enable: assert property ((feat_en.wdt || feat_en.pwrt || is_internal) |-> slow_osc_en)
        else $error("slow oscillator not enabled");

    a_fast_tick_gated: assert property (fast_tick |-> $past(fast_osc_en))
        else $error("fast oscillator ran while disabled");

    a_fast_direct: assert property ((fosc_tick && is_internal && $past(is_internal)
        && $past(internal_freq_select) == ssc_pkg::SEL_FAST) |-> $past(fast_tick))
        else $error("select 111 did not pass the fast clock");

    a_slow_trim_take: assert property (slow_tick |=> trim_slow == $past(freq_trim))
        else $error("slow oscillator missed the new trim");

    c_pll_tick: cover property (pll_en && pll_tick ##1 !pll_tick ##[1:40] pll_tick);
    c_trim_write: cover property (trim_wr ##1 settle_busy);
    c_int_postscale: cover property (is_internal && fosc_tick && internal_freq_select == 3'h6);
    c_ext_ready: cover property (is_ext && sys_clk_ready && fosc_tick);

endmodule
`default_nettype wire

// [verification/ssc_ext_clk_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ssc_ext_clk_model #(
    parameter int HALF_NS = 40
) (
    input  wire logic run,
    output logic      clk_out
);
    // A gated source: it rests low between bursts instead of free running
    initial clk_out = 1'b0;
    always begin
        #(HALF_NS);
        clk_out = run ? ~clk_out : 1'b0;
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                  sys_clk = 1'b0;
    logic                  rst_b   = 1'b0;
    ssc_pkg::ssc_bus_req_t bus_req = '0;
    ssc_pkg::ssc_feat_t    feat    = '0;
    ssc_pkg::ssc_gp_drv_t  gp_drv  = '0;
    ssc_pkg::ssc_mode_t    mode;
    logic [3:0]            cfg     = 4'h2;
    logic [7:0]            rdata, d;
    logic                  run = 1'b0, tb_in = 1'b0, tb_out = 1'b0, out_q = 1'b0;
    logic                  ext_clk, gp6, gp7, in_o, in_oe, out_o, out_oe;
    logic                  tick, ready, pll_en, fast_en, slow_en;
    int                    num_errors = 0, checked = 0, ticks = 0, rises = 0, dt, dr;
    int                    mc[10] = '{0, 1, 2, 4, 6, 7, 3, 5, 8, 9};

    always #2 sys_clk = ~sys_clk;

    ssc_ext_clk_model #(.HALF_NS(40)) src (.run(run), .clk_out(ext_clk));

    // Short settle and start-up counts keep the run brief
    ssc_clock_select #(.FAST_SETTLE_CYC(20), .OST_EDGES(4)) DUT (
        .sys_clk(sys_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(rdata),
        .osc_mode_config(cfg), .feat_en(feat), .gp_first_drv(gp_drv),
        .gp_first_bit6(gp6), .gp_first_bit7(gp7),
        .osc_in_pin_sense(in_oe ? in_o : (run ? ext_clk : tb_in)),
        .osc_in_pin_drive(in_o), .osc_in_pin_oe(in_oe),
        .osc_out_pin_sense(out_oe ? out_o : tb_out),
        .osc_out_pin_drive(out_o), .osc_out_pin_oe(out_oe), .fosc_tick(tick),
        .sys_clk_ready(ready), .pll_en(pll_en), .fast_osc_en(fast_en),
        .slow_osc_en(slow_en), .osc_mode(mode));

    always @(posedge sys_clk) begin
        ticks <= ticks + int'(tick);
        rises <= rises + int'(out_oe && out_o && !out_q);
        out_q <= out_oe && out_o;
    end

    task automatic chk(input logic [15:0] got, input int lo, input int hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("BAD %0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic reboot(input logic [3:0] c);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        cfg <= c;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic meas(input int n);
        int t0, r0;
        t0 = ticks;
        r0 = rises;
        repeat (n) @(posedge sys_clk);
        dt = ticks - t0;
        dr = rises - r0;
    endtask

    function automatic int trim_ticks(input int n, input int t);
        return int'((longint'(n) * (longint'(ssc_pkg::FAST_STEP)
            + t * longint'(ssc_pkg::FAST_TRIM_UNIT))) >>> ssc_pkg::ACC_W);
    endfunction

    task automatic t_regs();
        reboot(ssc_pkg::CFG_INT_ONE);
        rd(ssc_pkg::ADDR_TRIM);
        chk(d, 0, 0);
        wr(ssc_pkg::ADDR_TRIM, 8'hff);
        rd(ssc_pkg::ADDR_TRIM);
        chk(d, 8'h3f, 8'h3f);
        rd(ssc_pkg::ADDR_STATUS);
        chk(d, 8'hc8, 8'hc8);
        rd(8'h33);
        chk(d, 0, 0);
        wr(ssc_pkg::ADDR_TRIM, 8'h00);
    endtask

    task automatic t_modes();
        for (int i = 0; i < 10; i++) begin
            reboot(4'(i));
            chk({pll_en, mode}, (i == 6) * 16 + mc[i], (i == 6) * 16 + mc[i]);
            rd(ssc_pkg::ADDR_STATUS);
            chk(d[4:0], (i == 6) * 16 + mc[i], (i == 6) * 16 + mc[i]);
            if (i == 4 || i == 5) begin
                chk(ready, 1, 1);
            end
        end
    endtask

    task automatic t_ext(input logic [3:0] c, input int tk, input int rs);
        reboot(c);
        // Started after reset so back-to-back calls never set run twice in one step
        run <= 1'b1;
        repeat (200) @(posedge sys_clk);
        meas(800);
        chk(16'(dt), tk - 1, tk + 1);
        chk(16'(dr), (rs > 0) ? rs - 1 : 0, (rs > 0) ? rs + 1 : 0);
        run <= 1'b0;
    endtask

    task automatic t_gpio(input logic [3:0] c, input logic seven);
        reboot(c);
        gp_drv <= 4'hf;
        repeat (2) @(posedge sys_clk);
        chk(seven ? (in_oe & in_o) : (out_oe & out_o), 1, 1);
        gp_drv <= 4'h0;
        tb_in <= 1'b1;
        tb_out <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(seven ? gp7 : gp6, 1, 1);
        tb_in <= 1'b0;
        tb_out <= 1'b0;
    endtask

    task automatic t_int();
        reboot(ssc_pkg::CFG_INT_ONE);
        wr(ssc_pkg::ADDR_CTRL, 8'h70);
        rd(ssc_pkg::ADDR_CTRL);
        chk(d, 8'h70, 8'h70);
        meas(1000);
        chk(16'(dt), 31, 33);
        chk(16'(dr), 7, 9);
        chk({fast_en, slow_en, out_oe}, 7, 7);
        wr(ssc_pkg::ADDR_CTRL, 8'h60);
        meas(1000);
        chk(16'(dt), 15, 17);
        wr(ssc_pkg::ADDR_CTRL, 8'h00);
        #1 chk({fast_en, slow_en}, 1, 1);
        wr(ssc_pkg::ADDR_CTRL, 8'h70);
        wr(ssc_pkg::ADDR_TRIM, 8'h1f);
        repeat (40) @(posedge sys_clk);
        meas(2000);
        chk(16'(dt), trim_ticks(2000, 31) - 1, trim_ticks(2000, 31) + 1);
        wr(ssc_pkg::ADDR_TRIM, 8'h20);
        repeat (40) @(posedge sys_clk);
        meas(2000);
        chk(16'(dt), trim_ticks(2000, -32) - 1, trim_ticks(2000, -32) + 1);
    endtask

    task automatic t_feat();
        reboot(ssc_pkg::CFG_HI_SPD);
        for (int b = 0; b < 5; b++) begin
            feat <= ssc_pkg::ssc_feat_t'((b < 4) ? 4'h1 << b : 4'h0);
            repeat (2) @(posedge sys_clk);
            chk({slow_en, fast_en, pll_en}, (b < 4) * 4, (b < 4) * 4);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d checked=%0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        t_regs();
        t_modes();
        t_ext(ssc_pkg::CFG_EXT_DIV, 40, 10);
        t_ext(ssc_pkg::CFG_RC_DIV, 40, 10);
        t_ext(ssc_pkg::CFG_PLL, 160, 0);
        t_ext(ssc_pkg::CFG_HI_SPD, 40, 0);
        t_gpio(ssc_pkg::CFG_EXT_IO, 1'b0);
        t_gpio(ssc_pkg::CFG_RC_IO, 1'b0);
        t_gpio(ssc_pkg::CFG_INT_ONE, 1'b1);
        t_gpio(ssc_pkg::CFG_INT_TWO, 1'b1);
        t_gpio(ssc_pkg::CFG_INT_TWO, 1'b0);
        t_int();
        t_feat();
        wrap_up();
    end

    // Whole sequence needs about 10.5k cycles; this leaves ample margin
    initial begin
        #300000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
